/* common/scr_pkg.sv */
// constants for system clock distribution and reset pin control
`default_nettype none
package scr_pkg;
   // ****************************************
   // clock rates
   // ****************************************
   localparam int unsigned CLK_SYS_HZ = 25_000_000;
   localparam int unsigned BUS_DIV = 2;
   localparam int unsigned SYNC_STAGES = 2;

   // ****************************************
   // synchroniser input positions
   // ****************************************
   localparam int unsigned SI_INT_REF = 0;
   localparam int unsigned SI_EXT_REF = 1;
   localparam int unsigned SI_FLL = 2;
   localparam int unsigned SI_DCO = 3;
   localparam int unsigned SI_FF_SRC = 4;
   localparam int unsigned SI_LPO = 5;
   localparam int unsigned SI_XOSC = 6;
   localparam int unsigned SI_EXT_TIMER_CLK = 7;
   localparam int unsigned SI_RST_PIN = 8;
   localparam int unsigned N_SYNC = 9;

   // ****************************************
   // select codes and reset values
   // ****************************************
   localparam logic [1:0] MAIN_SEL_INT = 2'h0;
   localparam logic [1:0] MAIN_SEL_EXT = 2'h1;
   localparam logic [1:0] MAIN_SEL_FLL = 2'h2;
   localparam logic [1:0] MAIN_SEL_RST = MAIN_SEL_INT;
   localparam logic [1:0] TMR_SEL_BUS = 2'h0;
   localparam logic [1:0] TMR_SEL_FF = 2'h1;
   localparam logic [1:0] TMR_SEL_EXT_TIMER_CLK = 2'h2;
   localparam logic [1:0] TMR_SEL_RST = TMR_SEL_BUS;
   localparam logic [1:0] RTC_SEL_LPO = 2'h0;
   localparam logic [1:0] RTC_SEL_IREF = 2'h1;
   localparam logic [1:0] RTC_SEL_XOSC = 2'h2;
   localparam logic [1:0] RTC_SEL_RST = RTC_SEL_LPO;
   localparam logic WDOG_SEL_RST = 1'b0;
   localparam logic ADC_SEL_RST = 1'b0;

   // ****************************************
   // reset pin and reset status
   // ****************************************
   localparam logic [5:0] RST_DRIVE_BUS_CYC = 6'h22;
   localparam int unsigned RS_POR = 7;
   localparam int unsigned RS_PIN = 6;
   localparam int unsigned RS_WDOG = 5;
   localparam int unsigned RS_SW = 2;
   localparam int unsigned RS_LVD = 1;
   localparam logic [7:0] RS_RESET_VAL = 8'h80;
endpackage : scr_pkg
`default_nettype wire

/* rtl/scr_edge_sync.sv */
// two-stage synchroniser with rising edge pulse
`default_nettype none
module scr_edge_sync (
   input wire logic clk_in,     // system clock
   input wire logic rst_n_in,   // async reset, active low
   input wire logic d_in,       // asynchronous level
   output logic level_out,      // synchronised level
   output logic rise_out        // one-cycle pulse on rising edge
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic rise;
   } scr_sync_st_t;

   scr_sync_st_t st_r;
   scr_sync_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = d_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.rise = st_r.s2 & ~st_r.s3;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign level_out = st_r.s2;
   assign rise_out = st_r.rise;
endmodule : scr_edge_sync
`default_nettype wire

/* rtl/scr_rst_pin.sv */
// multiplexed reset pin, reset stretch and reset cause capture
`default_nettype none
module scr_rst_pin (
   input wire logic clk_in,       // system clock
   input wire logic rst_n_in,     // power-on reset, synced, active low
   input wire logic bus_en_in,    // bus clock enable
   input wire logic pin_lvl_in,   // synced pin level
   input wire logic en_set_in,    // pulse, enable reset function
   input wire logic lvd_rst_in,   // pulse, low voltage reset
   input wire logic wdog_rst_in,  // pulse, watchdog reset
   input wire logic sw_rst_in,    // pulse, other internal reset
   output logic pin_oe_out,       // pin driven low while high
   output logic pullup_en_out,    // internal pullup enable
   output logic pin_en_out,       // reset function enabled
   output logic gpio_out,         // pin as port input bit
   output logic sys_rst_out,      // system reset active high
   output logic [7:0] status_out  // reset cause flags
);
   typedef enum logic [1:0] {ST_IDLE, ST_DRIVE, ST_RECOVER} scr_rp_state_t;

   typedef struct packed {
      scr_rp_state_t state;
      logic en;
      logic [5:0] cnt;
      logic [7:0] status;
      logic gpio;
   } scr_rp_st_t;

   scr_rp_st_t st_r;
   scr_rp_st_t st_nxt;

   always_comb begin
      logic ext_low;
      logic any_int;
      ext_low = st_r.en & ~pin_lvl_in;
      any_int = lvd_rst_in | wdog_rst_in | sw_rst_in;
      st_nxt = st_r;
      st_nxt.gpio = pin_lvl_in;
      if (en_set_in) begin
         st_nxt.en = 1'b1;
      end
      unique case (st_r.state)
         ST_IDLE: begin
            if (any_int || ext_low) begin
               st_nxt.state = ST_DRIVE;
               st_nxt.cnt = '0;
               st_nxt.status = '0;
               if (lvd_rst_in) begin
                  st_nxt.status[scr_pkg::RS_LVD] = 1'b1;
                  st_nxt.en = 1'b0;
               end else if (wdog_rst_in) begin
                  st_nxt.status[scr_pkg::RS_WDOG] = 1'b1;
               end else if (sw_rst_in) begin
                  st_nxt.status[scr_pkg::RS_SW] = 1'b1;
               end else begin
                  st_nxt.status[scr_pkg::RS_PIN] = 1'b1;
               end
            end
         end
         ST_DRIVE: begin
            if (bus_en_in) begin
               st_nxt.cnt = st_r.cnt + 6'h01;
               if (st_r.cnt == scr_pkg::RST_DRIVE_BUS_CYC - 6'h01) begin
                  st_nxt.state = ST_RECOVER;
               end
            end
         end
         ST_RECOVER: begin
            // own drive must be seen released before pin is sampled again
            if (!st_r.en || pin_lvl_in) begin
               st_nxt.state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_r.state <= ST_IDLE;
         st_r.en <= 1'b0;
         st_r.cnt <= '0;
         st_r.status <= scr_pkg::RS_RESET_VAL;
         st_r.gpio <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pin_oe_out = st_r.en && (st_r.state == ST_DRIVE);
   assign pullup_en_out = st_r.en;
   assign pin_en_out = st_r.en;
   assign gpio_out = st_r.gpio;
   assign sys_rst_out = (st_r.state != ST_IDLE);
   assign status_out = st_r.status;
endmodule : scr_rst_pin
`default_nettype wire

/* rtl/scr_clk_rst_top.sv */
// system clock distribution and reset pin control top
// Functional notes
// - config selects are taken only on the bus clock enable
// - fixed-frequency clock synced to bus clock, at most half its rate
// - main generator output is cpu clock; bus clock is it divided by 2
// - main output source: internal ref, external ref or loop output
// - local oscillator clock offered when running from a reference
// - external reference clock selectable as converter clock
// - internal reference clock selectable for real-time counter
// - synced fixed-frequency clock selectable by both timers
// - low-power oscillator clock selectable by rtc or watchdog
// - crystal oscillator output selectable for real-time counter
// - after any reset the internal reference clock drives the chip
// - after power-on the reset pin is a plain input port bit
// - enable bit turns pin into open-drain active-low reset
// - reset function persists until power-on or low-voltage reset
// - enabled pin driven low from outside resets the device
// - every reset other than power-on and low-voltage drives enabled pin low 34 bus cycles
// - the cause that starts each reset sets its flag in the reset status; causes during a reset are ignored
`default_nettype none
module scr_clk_rst_top (
   input wire logic clk_sys_in,          // 25 MHz system clock
   input wire logic resetn_in,           // power-on reset, active low
   input wire logic int_ref_clk_in,      // internal reference clock
   input wire logic ext_ref_clk_in,      // external reference clock
   input wire logic fll_clk_in,          // loop output clock
   input wire logic dco_clk_in,          // local oscillator clock
   input wire logic fixed_freq_src_in,   // fixed-frequency source
   input wire logic low_power_osc_in,    // low-power oscillator clock
   input wire logic crystal_osc_in,      // crystal oscillator output
   input wire logic ext_timer_clk_in,    // external timer clock pin
   input wire logic rst_pin_in,          // reset pin level
   input wire logic cfg_wr_in,           // config request, hold to ack
   input wire logic [1:0] cfg_main_sel_in,  // main source select
   input wire logic [1:0] cfg_tpm_sel_in,   // timer/pwm clock select
   input wire logic [1:0] cfg_modulo_timer_sel_in,  // modulo timer clock select
   input wire logic [1:0] cfg_rtc_sel_in,   // rtc clock select
   input wire logic cfg_wdog_sel_in,     // watchdog clock select
   input wire logic cfg_adc_sel_in,      // converter clock select
   input wire logic cfg_rst_pin_en_in,   // reset pin enable
   input wire logic lvd_rst_in,          // pulse, low voltage reset
   input wire logic wdog_rst_in,         // pulse, watchdog reset
   input wire logic sw_rst_in,           // pulse, other internal reset
   output logic cfg_ack_out,             // config taken
   output logic clkgen_main_en_out,      // cpu clock enable
   output logic periph_bus_clk_en_out,   // bus clock enable
   output logic dco_local_clk_en_out,    // local clock enable
   output logic ext_ref_clk_en_out,      // external reference enable
   output logic int_ref_clk_en_out,      // internal reference enable
   output logic fixed_freq_clk_en_out,   // synced fixed-frequency enable
   output logic tpm_clk_en_out,          // timer/pwm clock enable
   output logic modulo_timer_clk_en_out,         // modulo timer clock enable
   output logic rtc_clk_en_out,          // rtc clock enable
   output logic wdog_clk_en_out,         // watchdog clock enable
   output logic adc_alt_clk_en_out,      // converter clock enable
   output logic ff_overrun_out,          // sticky, fixed clock too fast
   output logic ext_timer_clk_overrun_out,        // sticky, timer clock too fast
   output logic rst_pin_out,             // reset pin output value
   output logic rst_pin_oe_out,          // reset pin output enable
   output logic rst_pin_pullup_out,      // reset pin pullup enable
   output logic rst_pin_en_out,          // reset function enabled
   output logic port_a_bit5_out,         // pin as port input bit
   output logic sys_rst_out,             // system reset active high
   output logic [7:0] reset_status_out   // reset cause flags
);
   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic cpu_en;
      logic div;
      logic bus_en;
      logic ff_pend;
      logic ff_en;
      logic ff_ovr;
      logic tc_pend;
      logic tc_en;
      logic tc_ovr;
      logic [1:0] main_sel;
      logic [1:0] tpm_sel;
      logic [1:0] modulo_timer_sel;
      logic [1:0] rtc_sel;
      logic wdog_sel;
      logic adc_sel;
      logic tpm_en;
      logic modulo_timer_en;
      logic rtc_en;
      logic wdog_en;
      logic adc_en;
      logic dco_en;
      logic eref_en;
      logic iref_en;
   } scr_top_st_t;

   scr_top_st_t st_r;
   scr_top_st_t st_nxt;

   logic rst_n;
   logic [scr_pkg::N_SYNC-1:0] async_in;
   logic [scr_pkg::N_SYNC-1:0] lvl;
   logic [scr_pkg::N_SYNC-1:0] rise;
   logic rp_sys_rst;

   // ****************************************
   // reset release and input synchronisers
   // ****************************************
   scr_edge_sync u_rst_sync (
      .clk_in(clk_sys_in),
      .rst_n_in(resetn_in),
      .d_in(1'b1),
      .level_out(rst_n),
      .rise_out()
   );

   assign async_in[scr_pkg::SI_INT_REF] = int_ref_clk_in;
   assign async_in[scr_pkg::SI_EXT_REF] = ext_ref_clk_in;
   assign async_in[scr_pkg::SI_FLL] = fll_clk_in;
   assign async_in[scr_pkg::SI_DCO] = dco_clk_in;
   assign async_in[scr_pkg::SI_FF_SRC] = fixed_freq_src_in;
   assign async_in[scr_pkg::SI_LPO] = low_power_osc_in;
   assign async_in[scr_pkg::SI_XOSC] = crystal_osc_in;
   assign async_in[scr_pkg::SI_EXT_TIMER_CLK] = ext_timer_clk_in;
   assign async_in[scr_pkg::SI_RST_PIN] = rst_pin_in;

   genvar gi;
   generate
      for (gi = 0; gi < scr_pkg::N_SYNC; gi++) begin : g_sync
         scr_edge_sync u_sync (
            .clk_in(clk_sys_in),
            .rst_n_in(rst_n),
            .d_in(async_in[gi]),
            .level_out(lvl[gi]),
            .rise_out(rise[gi])
         );
      end
   endgenerate

   // ****************************************
   // reset pin control
   // ****************************************
   scr_rst_pin u_rst_pin (
      .clk_in(clk_sys_in),
      .rst_n_in(rst_n),
      .bus_en_in(st_r.bus_en),
      .pin_lvl_in(lvl[scr_pkg::SI_RST_PIN]),
      .en_set_in(cfg_ack_out & cfg_rst_pin_en_in),
      .lvd_rst_in(lvd_rst_in),
      .wdog_rst_in(wdog_rst_in),
      .sw_rst_in(sw_rst_in),
      .pin_oe_out(rst_pin_oe_out),
      .pullup_en_out(rst_pin_pullup_out),
      .pin_en_out(rst_pin_en_out),
      .gpio_out(port_a_bit5_out),
      .sys_rst_out(rp_sys_rst),
      .status_out(reset_status_out)
   );

   // config is taken only on a bus clock edge
   assign cfg_ack_out = cfg_wr_in & st_r.bus_en & ~rp_sys_rst;

   // ****************************************
   // clock enables and selects
   // ****************************************
   always_comb begin
      logic main_rise;
      logic bus_nxt;
      logic ff_any;
      logic tc_any;
      main_rise = 1'b0;
      st_nxt = st_r;
      unique case (st_r.main_sel)
         scr_pkg::MAIN_SEL_INT: main_rise = rise[scr_pkg::SI_INT_REF];
         scr_pkg::MAIN_SEL_EXT: main_rise = rise[scr_pkg::SI_EXT_REF];
         scr_pkg::MAIN_SEL_FLL: main_rise = rise[scr_pkg::SI_FLL];
         default: main_rise = rise[scr_pkg::SI_INT_REF];
      endcase
      st_nxt.cpu_en = main_rise;
      st_nxt.div = main_rise ? ~st_r.div : st_r.div;
      bus_nxt = main_rise & st_r.div;
      st_nxt.bus_en = bus_nxt;

      // edges wait for the next bus edge; a second one meanwhile is lost
      ff_any = st_r.ff_pend | rise[scr_pkg::SI_FF_SRC];
      st_nxt.ff_en = bus_nxt & ff_any;
      st_nxt.ff_pend = ff_any & ~bus_nxt;
      st_nxt.ff_ovr = st_r.ff_ovr
         | (st_r.ff_pend & rise[scr_pkg::SI_FF_SRC]);
      tc_any = st_r.tc_pend | rise[scr_pkg::SI_EXT_TIMER_CLK];
      st_nxt.tc_en = bus_nxt & tc_any;
      st_nxt.tc_pend = tc_any & ~bus_nxt;
      st_nxt.tc_ovr = st_r.tc_ovr
         | (st_r.tc_pend & rise[scr_pkg::SI_EXT_TIMER_CLK]);

      unique case (st_r.tpm_sel)
         scr_pkg::TMR_SEL_FF: st_nxt.tpm_en = st_nxt.ff_en;
         scr_pkg::TMR_SEL_EXT_TIMER_CLK: st_nxt.tpm_en = st_nxt.tc_en;
         default: st_nxt.tpm_en = bus_nxt;
      endcase
      unique case (st_r.modulo_timer_sel)
         scr_pkg::TMR_SEL_FF: st_nxt.modulo_timer_en = st_nxt.ff_en;
         scr_pkg::TMR_SEL_EXT_TIMER_CLK: st_nxt.modulo_timer_en = st_nxt.tc_en;
         default: st_nxt.modulo_timer_en = bus_nxt;
      endcase
      unique case (st_r.rtc_sel)
         scr_pkg::RTC_SEL_IREF:
            st_nxt.rtc_en = rise[scr_pkg::SI_INT_REF];
         scr_pkg::RTC_SEL_XOSC:
            st_nxt.rtc_en = rise[scr_pkg::SI_XOSC];
         default: st_nxt.rtc_en = rise[scr_pkg::SI_LPO];
      endcase
      st_nxt.wdog_en = st_r.wdog_sel ? rise[scr_pkg::SI_LPO]
                                     : bus_nxt;
      st_nxt.adc_en = st_r.adc_sel ? rise[scr_pkg::SI_EXT_REF]
                                   : bus_nxt;
      st_nxt.dco_en = rise[scr_pkg::SI_DCO]
         & (st_r.main_sel != scr_pkg::MAIN_SEL_FLL);
      st_nxt.eref_en = rise[scr_pkg::SI_EXT_REF];
      st_nxt.iref_en = rise[scr_pkg::SI_INT_REF];

      if (rp_sys_rst) begin
         // any reset falls back to the internal reference
         st_nxt.main_sel = scr_pkg::MAIN_SEL_RST;
         st_nxt.tpm_sel = scr_pkg::TMR_SEL_RST;
         st_nxt.modulo_timer_sel = scr_pkg::TMR_SEL_RST;
         st_nxt.rtc_sel = scr_pkg::RTC_SEL_RST;
         st_nxt.wdog_sel = scr_pkg::WDOG_SEL_RST;
         st_nxt.adc_sel = scr_pkg::ADC_SEL_RST;
      end else if (cfg_ack_out) begin
         st_nxt.main_sel = cfg_main_sel_in;
         st_nxt.tpm_sel = cfg_tpm_sel_in;
         st_nxt.modulo_timer_sel = cfg_modulo_timer_sel_in;
         st_nxt.rtc_sel = cfg_rtc_sel_in;
         st_nxt.wdog_sel = cfg_wdog_sel_in;
         st_nxt.adc_sel = cfg_adc_sel_in;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.main_sel <= scr_pkg::MAIN_SEL_RST;
         st_r.tpm_sel <= scr_pkg::TMR_SEL_RST;
         st_r.modulo_timer_sel <= scr_pkg::TMR_SEL_RST;
         st_r.rtc_sel <= scr_pkg::RTC_SEL_RST;
         st_r.wdog_sel <= scr_pkg::WDOG_SEL_RST;
         st_r.adc_sel <= scr_pkg::ADC_SEL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign clkgen_main_en_out = st_r.cpu_en;
   assign periph_bus_clk_en_out = st_r.bus_en;
   assign dco_local_clk_en_out = st_r.dco_en;
   assign ext_ref_clk_en_out = st_r.eref_en;
   assign int_ref_clk_en_out = st_r.iref_en;
   assign fixed_freq_clk_en_out = st_r.ff_en;
   assign tpm_clk_en_out = st_r.tpm_en;
   assign modulo_timer_clk_en_out = st_r.modulo_timer_en;
   assign rtc_clk_en_out = st_r.rtc_en;
   assign wdog_clk_en_out = st_r.wdog_en;
   assign adc_alt_clk_en_out = st_r.adc_en;
   assign ff_overrun_out = st_r.ff_ovr;
   assign ext_timer_clk_overrun_out = st_r.tc_ovr;
   assign rst_pin_out = 1'b0;
   assign sys_rst_out = rp_sys_rst;
endmodule : scr_clk_rst_top
`default_nettype wire

/* tb/scr_clk_rst_properties.sv */
// assertions on the clock and reset pin block ports
`default_nettype none
module scr_clk_rst_properties (
   input wire logic clk_sys_in,  // clock
   input wire logic resetn_in,  // por
   input wire logic cfg_wr_in,  // cfg req
   input wire logic wdog_rst_in,  // wdog
   input wire logic lvd_rst_in,  // lvd
   input wire logic cfg_ack_out,  // ack
   input wire logic clkgen_main_en_out,  // cpu en
   input wire logic periph_bus_clk_en_out,  // bus en
   input wire logic fixed_freq_clk_en_out,  // ff en
   input wire logic rst_pin_out,  // pin val
   input wire logic rst_pin_oe_out,  // pin oe
   input wire logic rst_pin_pullup_out,  // pullup
   input wire logic rst_pin_en_out,  // pin en
   input wire logic sys_rst_out,  // sys rst
   input wire logic [7:0] reset_status_out  // causes
);
   // ****************
   // bus pulses seen while pin driven
   // ****************
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   logic [7:0] oe_bus_r;
   logic [7:0] oe_bus_nxt;
   always_comb begin
      oe_bus_nxt = rst_pin_oe_out ?
         oe_bus_r + {7'h00, periph_bus_clk_en_out} : 8'h00;
   end
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) oe_bus_r <= 8'h00;
      else oe_bus_r <= oe_bus_nxt;
   end
   // ****************
   // properties
   // ****************
   chk_bus_on_main: assert property (
      periph_bus_clk_en_out |-> clkgen_main_en_out)
      else $error("bus pulse without cpu pulse");
   chk_ff_on_bus: assert property (
      fixed_freq_clk_en_out |-> periph_bus_clk_en_out)
      else $error("fixed clock pulse off the bus pulse");
   chk_ack_on_bus: assert property (
      cfg_ack_out |-> cfg_wr_in && periph_bus_clk_en_out && !sys_rst_out)
      else $error("config taken off the bus pulse");
   chk_pin_open_drain: assert property (
      !rst_pin_out && (rst_pin_pullup_out == rst_pin_en_out))
      else $error("pin drive or pullup wrong");
   chk_oe_needs_en: assert property (
      rst_pin_oe_out |-> rst_pin_en_out && sys_rst_out)
      else $error("pin driven while function off");
   chk_en_sticky: assert property (
      $fell(rst_pin_en_out) |-> reset_status_out[scr_pkg::RS_LVD])
      else $error("pin function lost without lvd");
   chk_drive_len: assert property (
      $fell(rst_pin_oe_out) |-> oe_bus_r == 8'h22)
      else $error("pin drive length wrong");
   chk_wdog_entry: assert property (
      wdog_rst_in && !lvd_rst_in && !sys_rst_out |=> sys_rst_out &&
      reset_status_out == 8'h20 && rst_pin_oe_out == $past(rst_pin_en_out))
      else $error("watchdog reset entry wrong");
   chk_por_state: assert property (
      $rose(resetn_in) |-> !rst_pin_en_out &&
      reset_status_out == scr_pkg::RS_RESET_VAL)
      else $error("power-on state wrong");
   cov_drive_end: cover property ($fell(rst_pin_oe_out));
   cov_cfg_taken: cover property (cfg_ack_out);
   cov_ff_pulse: cover property (fixed_freq_clk_en_out);
endmodule : scr_clk_rst_properties
bind scr_clk_rst_top scr_clk_rst_properties u_props (
   .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cfg_wr_in(cfg_wr_in),
   .wdog_rst_in(wdog_rst_in), .lvd_rst_in(lvd_rst_in),
   .cfg_ack_out(cfg_ack_out), .clkgen_main_en_out(clkgen_main_en_out),
   .periph_bus_clk_en_out(periph_bus_clk_en_out),
   .fixed_freq_clk_en_out(fixed_freq_clk_en_out),
   .rst_pin_out(rst_pin_out), .rst_pin_oe_out(rst_pin_oe_out),
   .rst_pin_pullup_out(rst_pin_pullup_out),
   .rst_pin_en_out(rst_pin_en_out), .sys_rst_out(sys_rst_out),
   .reset_status_out(reset_status_out));
`default_nettype wire

/* tb/scr_clk_rst_top_tb_top.sv */
// self-checking bench for the clock and reset pin top
`default_nettype none
module scr_clk_rst_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ****************
   // stimulus and design
   // ****************
   logic clk_sys_in = 1'b0;
   logic resetn_in, int_ref_clk_in, ext_ref_clk_in, fll_clk_in;
   logic dco_clk_in, fixed_freq_src_in, low_power_osc_in, crystal_osc_in;
   logic ext_timer_clk_in, rst_pin_in, cfg_wr_in, cfg_wdog_sel_in;
   logic [1:0] cfg_main_sel_in, cfg_tpm_sel_in, cfg_modulo_timer_sel_in;
   logic [1:0] cfg_rtc_sel_in;
   logic cfg_adc_sel_in, cfg_rst_pin_en_in, lvd_rst_in, wdog_rst_in;
   logic sw_rst_in, cfg_ack_out, clkgen_main_en_out, periph_bus_clk_en_out;
   logic dco_local_clk_en_out, ext_ref_clk_en_out, int_ref_clk_en_out;
   logic fixed_freq_clk_en_out, tpm_clk_en_out, modulo_timer_clk_en_out;
   logic rtc_clk_en_out, wdog_clk_en_out, adc_alt_clk_en_out;
   logic ff_overrun_out, ext_timer_clk_overrun_out, rst_pin_out, rst_pin_oe_out;
   logic rst_pin_pullup_out, rst_pin_en_out, port_a_bit5_out, sys_rst_out;
   logic [7:0] reset_status_out;
   logic [7:0] ph = 8'h00;
   logic ext_low;
   int err_count = 0;
   int tests_run = 0;
   logic [9:0] rows [4] = '{10'h010, 10'h167, 10'h289, 10'h302};
   // clocks from one counter, rates within the sync limits
   assign {ext_timer_clk_in, fixed_freq_src_in} = {ph[5], ph[4]};
   assign {low_power_osc_in, crystal_osc_in, fll_clk_in} = {ph[3:2], ph[2]};
   assign {dco_clk_in, ext_ref_clk_in, int_ref_clk_in} = {ph[1], ph[1], ph[0]};
   // open-drain pin with pullup
   assign rst_pin_in = !(ext_low | (rst_pin_oe_out & !rst_pin_out));
   scr_clk_rst_top DUT (.*);
   initial begin
      clk_sys_in = 1'b0;
      forever #20 clk_sys_in = ~clk_sys_in;
   end
   always @(negedge clk_sys_in) ph <= ph + 8'h01;
   // ****************
   // compare tasks
   // ****************
   task automatic chk_bit(input logic g, input logic e, input string m);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t %s got %b", $time, m, g);
      end
   endtask : chk_bit
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t status %h exp %h", $time, g, e);
      end
   endtask : chk_byte
   task automatic chk_cnt(input int g, input int e, input int k);
      tests_run++;
      if (g != e) begin
         err_count++;
         $display("CHECK FAILED %0t cnt %0d got %0d exp %0d", $time, k, g, e);
      end
   endtask : chk_cnt
   task automatic print_verdict;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : print_verdict
   // ****************
   // bus tasks
   // ****************
   task automatic cfg(input logic [9:0] r);
      int n;
      n = 0;
      {cfg_main_sel_in, cfg_tpm_sel_in, cfg_modulo_timer_sel_in} = r[9:4];
      {cfg_rtc_sel_in, cfg_wdog_sel_in, cfg_adc_sel_in} = r[3:0];
      cfg_wr_in = 1'b1;
      #1;
      while (cfg_ack_out !== 1'b1 && n < 50) begin
         @(negedge clk_sys_in);
         #1;
         n++;
      end
      chk_bit(cfg_ack_out, 1'b1, "ack");
      @(negedge clk_sys_in);
      cfg_wr_in = 1'b0;
   endtask : cfg
   function automatic int tsel(input logic [1:0] s, input int b);
      return (s == 2'h0) ? b : (s == 2'h1) ? 4 : 2;
   endfunction : tsel
   task automatic measure(input logic [9:0] r);
      int c[11];
      int e[11];
      int b;
      logic [10:0] v;
      b = (r[9:8] == 2'h2) ? 8 : (r[9:8] == 2'h1) ? 16 : 32;
      e = '{2 * b, b, (r[9:8] == 2'h2) ? 0 : 32, 32, 64, 4,
         tsel(r[7:6], b), tsel(r[5:4], b),
         (r[3:2] == 2'h0) ? 8 : (r[3:2] == 2'h1) ? 64 : 16,
         r[1] ? 8 : b, r[0] ? 32 : b};
      c = '{default: 0};
      repeat (64) @(negedge clk_sys_in);
      repeat (128) begin
         v = {clkgen_main_en_out, periph_bus_clk_en_out, dco_local_clk_en_out,
            ext_ref_clk_en_out, int_ref_clk_en_out, fixed_freq_clk_en_out,
            tpm_clk_en_out, modulo_timer_clk_en_out, rtc_clk_en_out,
            wdog_clk_en_out, adc_alt_clk_en_out};
         for (int k = 0; k < 11; k++) c[k] += int'(v[10 - k] !== 1'b0);
         @(negedge clk_sys_in);
      end
      for (int k = 0; k < 11; k++) begin
         chk_cnt(c[k], e[k], k);
      end
   endtask : measure
   // cause 0 lvd, 1 watchdog, 2 other internal, 3 pin held low
   task automatic seq(input int c, input logic [7:0] st, input int eb);
      int n, bc, ac;
      n = 0;
      bc = 0;
      ac = 0;
      {lvd_rst_in, wdog_rst_in, sw_rst_in, ext_low} =
         {c == 0, c == 1, c == 2, c == 3};
      @(negedge clk_sys_in);
      {lvd_rst_in, wdog_rst_in, sw_rst_in} = 3'h0;
      while (sys_rst_out !== 1'b1 && n < 10) begin
         @(negedge clk_sys_in);
         n++;
      end
      ext_low = 1'b0;
      cfg_wr_in = 1'b1;
      chk_byte(reset_status_out, st);
      while (sys_rst_out === 1'b1 && n < 300) begin
         bc += int'((rst_pin_oe_out & periph_bus_clk_en_out) !== 1'b0);
         ac += int'(cfg_ack_out !== 1'b0);
         if (n == 20) sw_rst_in = 1'b1;
         else if (n == 21) sw_rst_in = 1'b0;
         @(negedge clk_sys_in);
         n++;
      end
      cfg_wr_in = 1'b0;
      chk_bit(sys_rst_out, 1'b0, "reset end");
      chk_byte(reset_status_out, st);
      chk_cnt(ac, 0, 20);
      if (eb >= 0) chk_cnt(bc, eb, 21);
   endtask : seq
   // ****************
   // main sequence
   // ****************
   initial begin
      {resetn_in, cfg_wr_in, cfg_rst_pin_en_in, ext_low} = 4'h0;
      {lvd_rst_in, wdog_rst_in, sw_rst_in} = 3'h0;
      {cfg_main_sel_in, cfg_tpm_sel_in, cfg_modulo_timer_sel_in} = 6'h00;
      {cfg_rtc_sel_in, cfg_wdog_sel_in, cfg_adc_sel_in} = 4'h0;
      repeat (2) @(negedge clk_sys_in);
      resetn_in = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      chk_byte(reset_status_out, 8'h80);
      chk_bit(rst_pin_en_out, 1'b0, "pin en");
      measure(10'h000);
      foreach (rows[i]) begin
         cfg(rows[i]);
         measure(rows[i]);
      end
      chk_bit(ff_overrun_out | ext_timer_clk_overrun_out, 1'b0, "overrun");
      ext_low = 1'b1;
      repeat (6) @(negedge clk_sys_in);
      chk_bit(port_a_bit5_out | sys_rst_out, 1'b0, "gpio low");
      ext_low = 1'b0;
      repeat (6) @(negedge clk_sys_in);
      chk_bit(port_a_bit5_out, 1'b1, "gpio high");
      cfg_rst_pin_en_in = 1'b1;
      cfg(rows[3]);
      cfg_rst_pin_en_in = 1'b0;
      chk_bit(rst_pin_pullup_out, 1'b1, "pullup");
      seq(1, 8'h20, 34);
      measure(10'h000);
      seq(3, 8'h40, 34);
      seq(2, 8'h04, 34);
      chk_bit(rst_pin_en_out, 1'b1, "pin en kept");
      seq(0, 8'h02, -1);
      chk_bit(rst_pin_en_out, 1'b0, "pin en lvd");
      seq(1, 8'h20, 0);
      cfg_rst_pin_en_in = 1'b1;
      cfg(rows[3]);
      resetn_in = 1'b0;
      @(negedge clk_sys_in);
      resetn_in = 1'b1;
      repeat (4) @(negedge clk_sys_in);
      chk_bit(rst_pin_en_out, 1'b0, "pin en por");
      print_verdict();
   end
   initial begin
      #(40 * 10000);
      err_count++;
      print_verdict();
   end
endmodule : scr_clk_rst_top_tb_top
`default_nettype wire
